// [src/tcc_channel.sv]
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - select 00 is output mode with free value access; other codes are input mode
// - software reaches preload except a lone input-mode low-byte read; compare mode copies preload into shadow
// - capture loads shadow then preload; preload frozen during a 16-bit read
// - after a finished read, a lone input-mode low-byte read returns current counter low byte
// - high byte written first; shadow update blocked until low byte written
// - pin sampled, filtered, polarity edge detected, used as trigger or prescaled capture
// - each valid capture edge latches counter and sets capture flag
// - interrupt raised for a channel flag only when its enable bit set
// - capture while capture flag still set also sets overcapture flag
// - capture flag cleared by writing 0 or low-byte read; overcapture by writing 0
// - select 01 links own pin, input mode, value register read-only
// - filter code 0011 accepts a level after eight equal clock samples
// - polarity 0 captures rising edge, 1 captures falling edge
// - prescale code 00 captures on every valid transition
// - pin capture only while channel enable bit set; software generate needs input mode only
// - software generate bit acts as a hardware capture event
// - second channel select 10 takes first pin's filtered signal
// - trigger select 101 uses pin one edge; slave mode 100 resets counter
// - active-high reference waveform, polarity applied at output end
// - compare mode 101 forces reference high, 100 forces it low
// - comparison keeps setting compare flag while output is forced
module tcc_channel (
  // clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         rstn_i,
  // avalon-mm slave
  input  wire logic [tcc_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [tcc_pkg::DATA_W-1:0]   avs_writedata_i,
  output logic      [tcc_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                              avs_waitrequest_o,
  // counter side
  input  wire logic [15:0]                  counter_i,
  output logic                              trigger_o,
  output logic                              counter_reset_o,
  output logic                              irq_o,
  // channel pins
  input  wire logic [tcc_pkg::NUM_CH-1:0]   channel_pin_i,
  output logic      [tcc_pkg::NUM_CH-1:0]   compare_output_pin_o,
  output logic      [tcc_pkg::NUM_CH-1:0]   compare_output_pin_oe_o,
  output logic      [tcc_pkg::NUM_CH-1:0]   reference_waveform_o
);
  import tcc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] tcc_filter_len(input logic [3:0] code);
    logic [3:0] len;
    len = FLT_LEN_8;
    if (code == FLT_CODE_1) begin
      len = FLT_LEN_1;
    end else if (code == FLT_CODE_2) begin
      len = FLT_LEN_2;
    end else if (code == FLT_CODE_4) begin
      len = FLT_LEN_4;
    end
    return len;
  endfunction : tcc_filter_len

  function automatic logic [2:0] tcc_psc_top(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction : tcc_psc_top

  function automatic logic tcc_is_input(input logic [7:0] mode);
    return mode[MODE_SEL_LSB +: 2] != SEL_OUTPUT;
  endfunction : tcc_is_input

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic       rst_meta;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake

  logic                 req;
  logic                 take;
  logic                 wr_take;
  logic                 rd_take;

  assign req     = avs_read_i | avs_write_i;
  assign take    = req & ~avs_waitrequest_o;
  assign wr_take = take & avs_write_i;
  assign rd_take = take & avs_read_i;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0]           mode [NUM_CH];
  logic [7:0]           chen;
  logic [7:0]           ier;
  logic [7:0]           smcr;
  logic [NUM_CH-1:0]    in_mode;
  logic [NUM_CH-1:0]    ch_en;
  logic [NUM_CH-1:0]    ch_pol;
  logic [NUM_CH-1:0]    ch_ie;
  logic [NUM_CH-1:0]    soft_gen;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode[0] <= RST_BYTE;
      mode[1] <= RST_BYTE;
      chen    <= RST_BYTE;
      ier     <= RST_BYTE;
      smcr    <= RST_BYTE;
    end else if (wr_take) begin
      unique case (avs_address_i)
        OFF_MODE1: mode[0] <= avs_writedata_i[7:0];
        OFF_MODE2: mode[1] <= avs_writedata_i[7:0];
        OFF_CHEN:  chen    <= avs_writedata_i[7:0];
        OFF_IER:   ier     <= avs_writedata_i[7:0];
        OFF_SMCR:  smcr    <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      in_mode[c]  = tcc_is_input(mode[c]);
      ch_en[c]    = chen[c*CHEN_STRIDE + CHEN_EN_LSB];
      ch_pol[c]   = chen[c*CHEN_STRIDE + CHEN_POL_LSB];
      ch_ie[c]    = ier[FLAG_LSB + c];
      soft_gen[c] = wr_take && (avs_address_i == OFF_EGR) &&
                    avs_writedata_i[FLAG_LSB + c];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input stage: sample, filter, edge

  logic [NUM_CH-1:0]    pin_smp;
  logic [NUM_CH-1:0]    filtered_input;
  logic [NUM_CH-1:0]    filt_prev;
  logic [3:0]           filt_cnt [NUM_CH];
  logic [NUM_CH-1:0]    filt_rise;
  logic [NUM_CH-1:0]    filt_fall;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_smp        <= '0;
      filtered_input <= '0;
      filt_prev      <= '0;
      filt_cnt[0]    <= 4'h0;
      filt_cnt[1]    <= 4'h0;
    end else begin
      pin_smp   <= channel_pin_i;
      filt_prev <= filtered_input;
      for (int p = 0; p < NUM_CH; p++) begin
        if (pin_smp[p] == filtered_input[p]) begin
          filt_cnt[p] <= 4'h0;
        end else if (filt_cnt[p] + 4'h1 >= tcc_filter_len(mode[p][MODE_FLT_LSB +: 4])) begin
          filtered_input[p] <= pin_smp[p];
          filt_cnt[p]       <= 4'h0;
        end else begin
          filt_cnt[p] <= filt_cnt[p] + 4'h1;
        end
      end
    end
  end

  assign filt_rise = filtered_input & ~filt_prev;
  assign filt_fall = ~filtered_input & filt_prev;

  //////////////////////////////////////////////////////////////////////////////
  // edge select, prescaler, capture command

  logic [NUM_CH-1:0]    edge_detected_input;
  logic [2:0]           psc_cnt [NUM_CH];
  logic [NUM_CH-1:0]    capture_input_signal;
  logic [NUM_CH-1:0]    cap_ev;
  logic                 pin1_edge;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      unique case (mode[c][MODE_SEL_LSB +: 2])
        SEL_OWN_PIN: edge_detected_input[c] =
          ch_pol[c] ? filt_fall[c] : filt_rise[c];
        SEL_OTHER_PIN: edge_detected_input[c] =
          ch_pol[c] ? filt_fall[1-c] : filt_rise[1-c];
        default: edge_detected_input[c] = 1'b0;
      endcase
      capture_input_signal[c] = edge_detected_input[c] & ch_en[c] & in_mode[c] &
                                (psc_cnt[c] == tcc_psc_top(mode[c][MODE_PSC_LSB +: 2]));
      cap_ev[c] = capture_input_signal[c] | (soft_gen[c] & in_mode[c]);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      psc_cnt[0] <= 3'h0;
      psc_cnt[1] <= 3'h0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!ch_en[c] || !in_mode[c] || capture_input_signal[c]) begin
          psc_cnt[c] <= 3'h0;
        end else if (edge_detected_input[c]) begin
          psc_cnt[c] <= psc_cnt[c] + 3'h1;
        end
      end
    end
  end

  // trigger path toward the counter controller
  assign pin1_edge = ch_pol[0] ? filt_fall[0] : filt_rise[0];

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trigger_o       <= 1'b0;
      counter_reset_o <= 1'b0;
    end else begin
      trigger_o       <= (smcr[SMCR_TS_LSB +: 3] == TS_PIN1_EDGE) & pin1_edge;
      counter_reset_o <= (smcr[SMCR_TS_LSB +: 3] == TS_PIN1_EDGE) & pin1_edge &
                         (smcr[SMCR_SMS_LSB +: 3] == SMS_RESET);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // value registers: preload and shadow

  logic [15:0]          preload [NUM_CH];
  logic [15:0]          shadow [NUM_CH];
  logic [NUM_CH-1:0]    wr_block;
  logic [NUM_CH-1:0]    rd_frozen;
  logic [NUM_CH-1:0]    hi_wr;
  logic [NUM_CH-1:0]    lo_wr;
  logic [NUM_CH-1:0]    hi_rd;
  logic [NUM_CH-1:0]    lo_rd;
  logic [NUM_CH-1:0]    hi_req;

  always_comb begin
    hi_req[0] = avs_read_i && avs_address_i == OFF_VAL1H;
    hi_req[1] = avs_read_i && avs_address_i == OFF_VAL2H;
    hi_wr[0] = wr_take && avs_address_i == OFF_VAL1H;
    lo_wr[0] = wr_take && avs_address_i == OFF_VAL1L;
    hi_rd[0] = rd_take && avs_address_i == OFF_VAL1H;
    lo_rd[0] = rd_take && avs_address_i == OFF_VAL1L;
    hi_wr[1] = wr_take && avs_address_i == OFF_VAL2H;
    lo_wr[1] = wr_take && avs_address_i == OFF_VAL2L;
    hi_rd[1] = rd_take && avs_address_i == OFF_VAL2H;
    lo_rd[1] = rd_take && avs_address_i == OFF_VAL2L;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      preload[0] <= RST_VALUE;
      preload[1] <= RST_VALUE;
      shadow[0]  <= RST_VALUE;
      shadow[1]  <= RST_VALUE;
      wr_block   <= '0;
      rd_frozen  <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (in_mode[c]) begin
          wr_block[c] <= 1'b0;
          if (cap_ev[c]) begin
            shadow[c] <= counter_i;
          end
          if (hi_rd[c]) begin
            rd_frozen[c] <= 1'b1;
          end else if (lo_rd[c]) begin
            rd_frozen[c] <= 1'b0;
          end
          // pending high-byte read already holds the preload
          if (!rd_frozen[c] && !hi_req[c]) begin
            preload[c] <= shadow[c];
          end
        end else begin
          rd_frozen[c] <= 1'b0;
          if (hi_wr[c]) begin
            preload[c][15:8] <= avs_writedata_i[7:0];
            wr_block[c]      <= 1'b1;
          end else if (lo_wr[c]) begin
            preload[c][7:0] <= avs_writedata_i[7:0];
            wr_block[c]     <= 1'b0;
          end
          if (!wr_block[c] && !hi_wr[c]) begin
            shadow[c] <= preload[c];
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // compare, flags, interrupt

  logic [NUM_CH-1:0]    match;
  logic [NUM_CH-1:0]    match_prev;
  logic [NUM_CH-1:0]    cmp_ev;
  logic [NUM_CH-1:0]    channel_event_flag;
  logic [NUM_CH-1:0]    overcapture_flag;
  logic [NUM_CH-1:0]    flag_set;
  logic [NUM_CH-1:0]    flag_clr;
  logic [NUM_CH-1:0]    ovr_clr;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      match[c]    = ~in_mode[c] & (counter_i == shadow[c]);
      cmp_ev[c]   = match[c] & ~match_prev[c];
      flag_set[c] = cap_ev[c] | cmp_ev[c] | (soft_gen[c] & ~in_mode[c]);
      flag_clr[c] = (wr_take && avs_address_i == OFF_SR1 &&
                     !avs_writedata_i[FLAG_LSB + c]) ||
                    (lo_rd[c] && in_mode[c]);
      ovr_clr[c]  = wr_take && avs_address_i == OFF_SR2 &&
                    !avs_writedata_i[FLAG_LSB + c];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      match_prev         <= '0;
      channel_event_flag <= '0;
      overcapture_flag   <= '0;
      irq_o              <= 1'b0;
    end else begin
      match_prev <= match;
      for (int c = 0; c < NUM_CH; c++) begin
        if (flag_set[c]) begin
          channel_event_flag[c] <= 1'b1;
        end else if (flag_clr[c]) begin
          channel_event_flag[c] <= 1'b0;
        end
        if (cap_ev[c] && channel_event_flag[c]) begin
          overcapture_flag[c] <= 1'b1;
        end else if (ovr_clr[c]) begin
          overcapture_flag[c] <= 1'b0;
        end
      end
      irq_o <= |(channel_event_flag & ch_ie);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output stage

  logic [NUM_CH-1:0]    next_ref;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      next_ref[c] = reference_waveform_o[c];
      if (!in_mode[c]) begin
        if (mode[c][MODE_OCM_LSB +: 3] == OCM_FORCE_HI) begin
          next_ref[c] = 1'b1;
        end else if (mode[c][MODE_OCM_LSB +: 3] == OCM_FORCE_LO) begin
          next_ref[c] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reference_waveform_o    <= '0;
      compare_output_pin_o    <= '0;
      compare_output_pin_oe_o <= '0;
    end else begin
      reference_waveform_o    <= next_ref;
      compare_output_pin_o    <= next_ref ^ ch_pol;
      compare_output_pin_oe_o <= ch_en & ~in_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0]           next_rd_byte;

  always_comb begin
    next_rd_byte = 8'h00;
    unique case (avs_address_i)
      OFF_MODE1: next_rd_byte = mode[0];
      OFF_MODE2: next_rd_byte = mode[1];
      OFF_CHEN:  next_rd_byte = chen;
      OFF_IER:   next_rd_byte = ier;
      OFF_SMCR:  next_rd_byte = smcr;
      OFF_SR1:   next_rd_byte = 8'({channel_event_flag, 1'b0});
      OFF_SR2:   next_rd_byte = 8'({overcapture_flag, 1'b0});
      OFF_VAL1H: next_rd_byte = preload[0][15:8];
      OFF_VAL2H: next_rd_byte = preload[1][15:8];
      OFF_VAL1L: next_rd_byte = (in_mode[0] && !rd_frozen[0]) ?
                                counter_i[7:0] : preload[0][7:0];
      OFF_VAL2L: next_rd_byte = (in_mode[1] && !rd_frozen[1]) ?
                                counter_i[7:0] : preload[1][7:0];
      default: next_rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= {24'h000000, next_rd_byte};
    end
  end

endmodule : tcc_channel

`default_nettype wire

// [src/tcc_pkg.sv]
package tcc_pkg;

  // bus geometry
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 32;
  localparam int          NUM_CH        = 2;

  // register offsets (byte addresses, one word each)
  localparam logic [5:0]  OFF_MODE1     = 6'h00;
  localparam logic [5:0]  OFF_MODE2     = 6'h04;
  localparam logic [5:0]  OFF_CHEN      = 6'h08;
  localparam logic [5:0]  OFF_IER       = 6'h0C;
  localparam logic [5:0]  OFF_SR1       = 6'h10;
  localparam logic [5:0]  OFF_SR2       = 6'h14;
  localparam logic [5:0]  OFF_EGR       = 6'h18;
  localparam logic [5:0]  OFF_SMCR      = 6'h1C;
  localparam logic [5:0]  OFF_VAL1H     = 6'h20;
  localparam logic [5:0]  OFF_VAL1L     = 6'h24;
  localparam logic [5:0]  OFF_VAL2H     = 6'h28;
  localparam logic [5:0]  OFF_VAL2L     = 6'h2C;

  // field positions
  localparam int          MODE_SEL_LSB  = 0;
  localparam int          MODE_PSC_LSB  = 2;
  localparam int          MODE_FLT_LSB  = 4;
  localparam int          MODE_OCM_LSB  = 4;
  localparam int          CHEN_EN_LSB   = 0;
  localparam int          CHEN_POL_LSB  = 1;
  localparam int          CHEN_STRIDE   = 4;
  localparam int          FLAG_LSB      = 1;
  localparam int          SMCR_SMS_LSB  = 0;
  localparam int          SMCR_TS_LSB   = 4;

  // encodings
  localparam logic [1:0]  SEL_OUTPUT    = 2'h0;
  localparam logic [1:0]  SEL_OWN_PIN   = 2'h1;
  localparam logic [1:0]  SEL_OTHER_PIN = 2'h2;
  localparam logic [2:0]  OCM_FORCE_LO  = 3'h4;
  localparam logic [2:0]  OCM_FORCE_HI  = 3'h5;
  localparam logic [2:0]  TS_PIN1_EDGE  = 3'h5;
  localparam logic [2:0]  SMS_RESET     = 3'h4;

  // filter sample counts per filter code
  localparam logic [3:0]  FLT_CODE_1    = 4'h0;
  localparam logic [3:0]  FLT_CODE_2    = 4'h1;
  localparam logic [3:0]  FLT_CODE_4    = 4'h2;
  localparam logic [3:0]  FLT_LEN_1     = 4'h1;
  localparam logic [3:0]  FLT_LEN_2     = 4'h2;
  localparam logic [3:0]  FLT_LEN_4     = 4'h4;
  localparam logic [3:0]  FLT_LEN_8     = 4'h8;

  // reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_VALUE     = 16'h0000;

endpackage : tcc_pkg

// [verif/tcc_channel_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module tcc_channel_monitor (
  // clock and reset
  input wire logic                       sys_clk_i,
  input wire logic                       rstn_i,
  // avalon-mm slave
  input wire logic [tcc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic                       avs_read_i,
  input wire logic                       avs_write_i,
  input wire logic [tcc_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [tcc_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic                       avs_waitrequest_o,
  // counter side
  input wire logic [15:0]                counter_i,
  input wire logic                       trigger_o,
  input wire logic                       counter_reset_o,
  input wire logic                       irq_o,
  // channel pins
  input wire logic [tcc_pkg::NUM_CH-1:0] channel_pin_i,
  input wire logic [tcc_pkg::NUM_CH-1:0] compare_output_pin_o,
  input wire logic [tcc_pkg::NUM_CH-1:0] compare_output_pin_oe_o,
  input wire logic [tcc_pkg::NUM_CH-1:0] reference_waveform_o
);
  import tcc_pkg::*;
  logic req;
  logic wacc;
  assign req  = avs_read_i | avs_write_i;
  assign wacc = avs_write_i & ~avs_waitrequest_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_answer;
    avs_waitrequest_o ##1 !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_recent_write;
    $past(wacc) || $past(wacc, 2);
  endsequence
  bus_answer_a: assert property ($rose(req) |-> s_answer)
    else $error("bus answer timing wrong");
  wait_with_req_a: assert property (!avs_waitrequest_o |-> req)
    else $error("waitrequest low without request");
  rdata_upper_a: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property ($changed(avs_readdata_o) |->
    avs_read_i && !avs_waitrequest_o)
    else $error("read data changed outside a read");
  trig_pulse_a: assert property (trigger_o |=> !trigger_o)
    else $error("trigger longer than one cycle");
  cnt_reset_a: assert property (counter_reset_o |-> trigger_o)
    else $error("counter reset without trigger");
  oe_stable_a: assert property ($changed(compare_output_pin_oe_o) |-> s_recent_write)
    else $error("output enable changed without write");
  ref_stable_a: assert property ($changed(reference_waveform_o) |-> s_recent_write)
    else $error("reference changed without write");
  pin_stable_a: assert property ($changed(compare_output_pin_o) |-> s_recent_write)
    else $error("output pin changed without write");
  cover property (counter_reset_o);
endmodule : tcc_channel_monitor
bind tcc_channel tcc_channel_monitor u_mon (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .counter_i(counter_i), .trigger_o(trigger_o), .counter_reset_o(counter_reset_o),
  .irq_o(irq_o), .channel_pin_i(channel_pin_i), .compare_output_pin_o(compare_output_pin_o),
  .compare_output_pin_oe_o(compare_output_pin_oe_o), .reference_waveform_o(reference_waveform_o));
`default_nettype wire

// [verif/tcc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  // clock
  input  wire logic       sys_clk_i,
  // requested level and chatter length
  input  wire logic [1:0] want_i,
  input  wire logic [2:0] bounce_i,
  // pins
  output logic      [1:0] pin_o
);
  logic [1:0] last = 2'h0;
  logic [2:0] left = 3'h0;
  logic [1:0] mask = 2'h0;
  initial pin_o = 2'h0;
  // only the contacts that moved chatter, for a few cycles before settling
  always @(posedge sys_clk_i) begin
    last  <= want_i;
    mask  <= (want_i != last) ? (want_i ^ last) : mask;
    left  <= (want_i != last) ? bounce_i : (left != 3'h0) ? left - 3'h1 : 3'h0;
    pin_o <= left[0] ? (want_i ^ mask) : want_i;
  end
endmodule : tcc_pin_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcc_pkg::*;
  logic                sys_clk_i = 1'b0;
  logic                rstn_i    = 1'b0;
  logic [ADDR_W-1:0]   address   = '0;
  logic                read      = 1'b0;
  logic                write     = 1'b0;
  logic [DATA_W-1:0]   writedata = '0;
  logic [15:0]         counter   = 16'hFFFF;
  logic [1:0]          want      = 2'h0;
  logic [2:0]          bounce    = 3'h0;
  logic [DATA_W-1:0]   readdata;
  logic                waitreq, trig, cnt_rst, irq;
  logic [NUM_CH-1:0]   pin, cmp, cmp_oe, refw;
  logic [7:0]          expq[$];
  logic [15:0]         seed      = 16'h0035;
  logic [15:0]         c, v;
  int                  error_cnt = 0;
  int                  comparisons = 0;
  int                  cycles    = 0;
  tcc_channel dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(address),
    .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(writedata),
    .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq), .counter_i(counter),
    .trigger_o(trig), .counter_reset_o(cnt_rst), .irq_o(irq), .channel_pin_i(pin),
    .compare_output_pin_o(cmp), .compare_output_pin_oe_o(cmp_oe), .reference_waveform_o(refw));
  tcc_pin_model u_pins (.sys_clk_i(sys_clk_i), .want_i(want), .bounce_i(bounce), .pin_o(pin));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #4 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    address   <= a;
    writedata <= {24'h000000, d};
    write     <= w;
    read      <= ~w;
    @(posedge sys_clk_i);
    while (waitreq !== 1'b0) begin
      @(posedge sys_clk_i);
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus
  task automatic wt(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wt
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic pinto(input logic l);
    want[0] <= l;
    cyc(24);
  endtask : pinto
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (read && waitreq === 1'b0) check("readdata", readdata[7:0], expq.pop_front());
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 6000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    int n;
    cyc(8);
    rstn_i <= 1'b1;
    cyc(3);
    rd(OFF_SR1, 8'h00);
    rd(6'h30, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wt(OFF_CHEN, {6'h00, i[1], 1'b1});
      wt(OFF_MODE1, i[0] ? 8'h50 : 8'h40);
      cyc(3);
      check("reference", refw[0], i[0]);
      check("pin", cmp[0], i[0] ^ i[1]);
      check("pin_oe", cmp_oe[0], 1'b1);
    end
    v = rnd() | 16'h0101;
    counter <= {v[15:8], 8'h00};
    wt(OFF_VAL1H, v[15:8]);
    cyc(3);
    rd(OFF_SR1, 8'h00);
    wt(OFF_VAL1L, v[7:0]);
    rd(OFF_VAL1H, v[15:8]);
    rd(OFF_VAL1L, v[7:0]);
    counter <= v;
    cyc(3);
    check("irq", irq, 1'b0);
    wt(OFF_IER, 8'h02);
    cyc(3);
    check("irq", irq, 1'b1);
    rd(OFF_SR1, 8'h02);
    counter <= ~v;
    wt(OFF_SR1, 8'h00);
    rd(OFF_SR1, 8'h00);
    wt(OFF_IER, 8'h00);
    $display("test output done");
    wt(OFF_MODE1, 8'h31);
    wt(OFF_CHEN, 8'h01);
    c = rnd();
    counter <= c;
    want[0] <= 1'b1;
    cyc(7);
    want[0] <= 1'b0;
    cyc(12);
    rd(OFF_SR1, 8'h00);
    bounce <= 3'h3;
    pinto(1'b1);
    rd(OFF_SR1, 8'h02);
    rd(OFF_VAL1H, c[15:8]);
    rd(OFF_VAL1L, c[7:0]);
    rd(OFF_SR1, 8'h00);
    pinto(1'b0);
    pinto(1'b1);
    counter <= ~c;
    pinto(1'b0);
    pinto(1'b1);
    rd(OFF_VAL1H, ~c[15:8]);
    counter <= c;
    pinto(1'b0);
    pinto(1'b1);
    rd(OFF_VAL1L, ~c[7:0]);
    counter <= v;
    cyc(2);
    rd(OFF_VAL1L, v[7:0]);
    rd(OFF_SR2, 8'h02);
    wt(OFF_SR1, 8'h00);
    rd(OFF_SR2, 8'h02);
    wt(OFF_SR2, 8'h00);
    rd(OFF_SR2, 8'h00);
    wt(OFF_VAL1H, ~c[15:8]);
    wt(OFF_VAL1L, ~c[7:0]);
    rd(OFF_VAL1H, c[15:8]);
    rd(OFF_VAL1L, c[7:0]);
    $display("test capture done");
    wt(OFF_CHEN, 8'h03);
    pinto(1'b0);
    rd(OFF_VAL1H, v[15:8]);
    rd(OFF_VAL1L, v[7:0]);
    pinto(1'b1);
    rd(OFF_SR1, 8'h00);
    wt(OFF_CHEN, 8'h02);
    pinto(1'b0);
    rd(OFF_SR1, 8'h00);
    wt(OFF_CHEN, 8'h01);
    wt(OFF_IER, 8'h02);
    counter <= ~v;
    wt(OFF_EGR, 8'h02);
    cyc(3);
    check("irq", irq, 1'b1);
    rd(OFF_VAL1H, ~v[15:8]);
    rd(OFF_VAL1L, ~v[7:0]);
    wt(OFF_IER, 8'h00);
    $display("test polarity done");
    bounce <= 3'h0;
    wt(OFF_MODE2, 8'h02);
    wt(OFF_CHEN, 8'h31);
    wt(OFF_SMCR, 8'h54);
    want[0] <= 1'b1;
    n = 0;
    while (trig !== 1'b1 && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    check("trigger", trig, 1'b1);
    check("counter_reset", cnt_rst, 1'b1);
    counter <= c;
    pinto(1'b0);
    rd(OFF_VAL2H, c[15:8]);
    rd(OFF_VAL2L, c[7:0]);
    $display("test pwm input done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
